// ### mhp_pkg.sv
// Shared types and constants for the parallel host port of the display controller.
// Assumes a single device clock; all pin inputs are asynchronous to it.
package mhp_pkg;

  localparam logic [2:0] SEL_SERIAL = 3'h0;
  localparam logic [2:0] SEL_I2C = 3'h2;
  localparam logic [2:0] SEL_P6800_8 = 3'h4;
  localparam logic [2:0] SEL_P6800_4 = 3'h5;
  localparam logic [2:0] SEL_P8080_8 = 3'h6;
  localparam logic [2:0] SEL_P8080_4 = 3'h7;

  localparam int SYNC_STAGES = 2;
  localparam int PIN_W = 16;
  localparam logic [7:0] DOUT_RST = 8'h00;
  localparam logic [7:0] OE_N_RST = 8'hFF;

  typedef enum logic [2:0] {
    MODE_SERIAL,
    MODE_I2C,
    MODE_P6800,
    MODE_P8080,
    MODE_INVALID
  } mhp_mode_e;

  // Raw host pins, as seen at the device boundary.
  typedef struct packed {
    logic chip_init_n;
    logic [2:0] iface_select;
    logic cs_n;
    logic dc;
    logic rw_wr_n;
    logic e_rd_n;
    logic [7:0] d;
  } mhp_pins_s;

  // One completed byte for the command decoder.
  typedef struct packed {
    logic valid;
    logic is_data;
    logic [7:0] data;
  } mhp_byte_s;

  // Pin mapping towards the serial and I2C engines.
  typedef struct packed {
    logic shift_clk;
    logic serial_in_line;
    logic i2c_scl;
    logic i2c_sda;
    logic addr_lsb_strap;
  } mhp_serial_s;

endpackage

// ### mhp_sync.sv
// Multi-bit two-stage synchroniser for the host pins.
// Assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/1ps
module mhp_sync #(
  parameter int WIDTH = 16,
  parameter int STAGES = 2
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] rst_value,
  output logic [WIDTH-1:0] sync_out
);

  logic [STAGES-1:0][WIDTH-1:0] stage_reg;

  // Refused at elaboration: one stage leaves metastability in the logic.
  if (STAGES < 2) begin : g_bad_stages
    $error("mhp_sync needs at least two stages");
  end

  // Reset loads a constant pattern from the instantiating module's tie-off.
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= rst_value;
      end
    end else if (ce) begin
      stage_reg[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule

// ### mhp_host_port.sv
// Parallel host port: strap decoding, 6800/8080 strobes, nibble sequencing
// and the display-data read pipeline, plus pin mapping for serial and I2C.
// Assumes the command decoder answers a fetch pulse with mem_rd_data on the
// very next enabled cycle, and that host strobes last several mclk periods.
`timescale 1ns/1ps
module mhp_host_port
  import mhp_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic srst,
  input wire mhp_pkg::mhp_pins_s pins,
  input wire logic [7:0] status_in,
  input wire logic [7:0] mem_rd_data,
  input wire logic serial_out_line,
  input wire logic i2c_sda_pull_low,
  output logic [7:0] d_out,
  output logic [7:0] d_oe_n,
  output mhp_pkg::mhp_byte_s byte_out,
  output logic mem_fetch,
  output mhp_pkg::mhp_serial_s serial_out,
  output mhp_pkg::mhp_mode_e bus_mode,
  output logic four_bit_mode
);
  import mhp_pkg::*;

  // Refused at elaboration: the nibble and pin mapping assume eight lines.
  if (DATA_W != 8) begin : g_bad_width
    $error("mhp_host_port serves an eight-bit data bus only");
  end

  typedef struct packed {
    logic [7:0] d_out;
    logic [7:0] d_oe_n;
    mhp_byte_s byte_out;
    logic fetch;
    logic fetch_load;
    logic [7:0] rd_latch;
    logic [3:0] nib_hold;
    logic nib_lo;
    logic prev_e_rd;
    logic prev_rw_wr;
    mhp_serial_s serial;
    mhp_mode_e mode;
    logic four_bit;
  } mhp_state_s;

  function automatic mhp_mode_e decode_mode(input logic [2:0] sel);
    unique case (sel)
      SEL_SERIAL: decode_mode = MODE_SERIAL;
      SEL_I2C: decode_mode = MODE_I2C;
      SEL_P6800_8, SEL_P6800_4: decode_mode = MODE_P6800;
      SEL_P8080_8, SEL_P8080_4: decode_mode = MODE_P8080;
      default: decode_mode = MODE_INVALID;
    endcase
  endfunction

  mhp_pins_s pin_sync;
  mhp_pins_s pin_rst;
  mhp_state_s st_reg;
  mhp_state_s st_next;

  // Select and write strobe idle inactive through reset; E/RD idles low, which is inactive for 6800 only.
  assign pin_rst = '{chip_init_n: 1'b1, iface_select: 3'h0, cs_n: 1'b1, dc: 1'b0,
                     rw_wr_n: 1'b1, e_rd_n: 1'b0, d: 8'h00};

  mhp_sync #(
    .WIDTH(PIN_W),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .mclk(mclk),
    .ce(ce),
    .srst(srst),
    .async_in(pins),
    .rst_value(pin_rst),
    .sync_out(pin_sync)
  );

  logic sel;
  logic wr_strobe_done;
  logic rd_strobe_done;
  logic rd_active;
  logic [7:0] rd_byte;
  logic byte_end;
  logic [7:0] full_byte;

  always_comb begin
    st_next = st_reg;
    st_next.byte_out.valid = 1'b0;
    st_next.fetch = 1'b0;
    st_next.fetch_load = 1'b0;
    st_next.prev_e_rd = pin_sync.e_rd_n;
    st_next.prev_rw_wr = pin_sync.rw_wr_n;
    st_next.mode = decode_mode(pin_sync.iface_select);
    st_next.four_bit = pin_sync.iface_select[2] & pin_sync.iface_select[0];
    sel = ~pin_sync.cs_n;
    wr_strobe_done = 1'b0;
    rd_strobe_done = 1'b0;
    rd_active = 1'b0;
    unique case (st_next.mode)
      MODE_P6800: begin
        // Direction is sampled at the falling edge, where the transfer lands.
        wr_strobe_done = sel & st_reg.prev_e_rd & ~pin_sync.e_rd_n & ~pin_sync.rw_wr_n;
        rd_strobe_done = sel & st_reg.prev_e_rd & ~pin_sync.e_rd_n & pin_sync.rw_wr_n;
        rd_active = sel & pin_sync.e_rd_n & pin_sync.rw_wr_n;
      end
      MODE_P8080: begin
        // A write is open from the strobe going low; data lands at its rising edge.
        wr_strobe_done = sel & ~st_reg.prev_rw_wr & pin_sync.rw_wr_n;
        rd_strobe_done = sel & ~st_reg.prev_e_rd & pin_sync.e_rd_n;
        rd_active = sel & ~pin_sync.e_rd_n;
      end
      default: begin
      end
    endcase

    // Status reads are live; display-data reads come from the pipeline latch.
    rd_byte = pin_sync.dc ? st_reg.rd_latch : status_in;
    full_byte = st_next.four_bit ? {st_reg.nib_hold, pin_sync.d[7:4]} : pin_sync.d;
    byte_end = ~st_next.four_bit | st_reg.nib_lo;

    if (wr_strobe_done | rd_strobe_done) begin
      if (st_next.four_bit) begin
        st_next.nib_lo = ~st_reg.nib_lo;
        st_next.nib_hold = pin_sync.d[7:4];
      end
    end
    if (wr_strobe_done & byte_end) begin
      st_next.byte_out.valid = 1'b1;
      st_next.byte_out.data = full_byte;
      st_next.byte_out.is_data = pin_sync.dc;
    end
    // Each completed data read advances the pipeline, so the first one is a dummy.
    if (rd_strobe_done & byte_end & pin_sync.dc) begin
      st_next.fetch = 1'b1;
    end
    st_next.fetch_load = st_reg.fetch;
    if (st_reg.fetch_load) begin
      st_next.rd_latch = mem_rd_data;
    end

    st_next.d_oe_n = OE_N_RST;
    st_next.d_out = DOUT_RST;
    if (rd_active) begin
      st_next.d_oe_n = st_next.four_bit ? 8'h0F : 8'h00;
      if (st_next.four_bit) begin
        st_next.d_out = {(st_reg.nib_lo ? rd_byte[3:0] : rd_byte[7:4]), 4'h0};
      end else begin
        st_next.d_out = rd_byte;
      end
    end else if (st_next.mode == MODE_SERIAL) begin
      st_next.d_oe_n = 8'hFB;
      st_next.d_out = {5'h00, serial_out_line, 2'h0};
    end else if (st_next.mode == MODE_I2C) begin
      // Open drain: the output is always low and only its enable moves.
      st_next.d_oe_n = {5'h1F, ~i2c_sda_pull_low, 2'h3};
    end

    st_next.serial.shift_clk = pin_sync.d[0];
    st_next.serial.serial_in_line = pin_sync.d[1];
    st_next.serial.i2c_scl = pin_sync.d[0];
    st_next.serial.i2c_sda = pin_sync.d[1];
    st_next.serial.addr_lsb_strap = (st_next.mode == MODE_I2C) & pin_sync.dc;

    // The host's reset pin returns the port to a known byte boundary.
    if (~pin_sync.chip_init_n) begin
      st_next.nib_lo = 1'b0;
      st_next.rd_latch = 8'h00;
      st_next.byte_out.valid = 1'b0;
      st_next.fetch = 1'b0;
      st_next.fetch_load = 1'b0;
      st_next.d_oe_n = OE_N_RST;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '{d_out: DOUT_RST, d_oe_n: OE_N_RST, byte_out: '0, fetch: 1'b0,
                  fetch_load: 1'b0, rd_latch: 8'h00, nib_hold: 4'h0, nib_lo: 1'b0,
                  prev_e_rd: 1'b0, prev_rw_wr: 1'b1, serial: '0,
                  mode: MODE_SERIAL, four_bit: 1'b0};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign d_out = st_reg.d_out;
  assign d_oe_n = st_reg.d_oe_n;
  assign byte_out = st_reg.byte_out;
  assign mem_fetch = st_reg.fetch;
  assign serial_out = st_reg.serial;
  assign bus_mode = st_reg.mode;
  assign four_bit_mode = st_reg.four_bit;

endmodule

// ### mhp_host_port_properties.sv
// Timing checks on the host port's pins, bound to its top module.
// Assumes ce is held high throughout.
`timescale 1ns/1ps
module mhp_host_port_properties
  import mhp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire mhp_pkg::mhp_pins_s pins,
  input wire logic [7:0] d_oe_n,
  input wire mhp_pkg::mhp_byte_s byte_out,
  input wire logic mem_fetch,
  input wire mhp_pkg::mhp_serial_s serial_out,
  input wire mhp_pkg::mhp_mode_e bus_mode,
  input wire logic four_bit_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_byte_pulse_once: assert property (byte_out.valid |=> !byte_out.valid)
    else $error("byte pulse too long");
  a_fetch_pulse_once: assert property (mem_fetch |=> !mem_fetch)
    else $error("fetch pulse too long");
  a_strap_6800: assert property ((pins.iface_select == SEL_P6800_8)[*4]
    |-> bus_mode == MODE_P6800 && !four_bit_mode) else $error("6800 strap wrong");
  a_strap_8080_nib: assert property ((pins.iface_select == SEL_P8080_4)[*4]
    |-> bus_mode == MODE_P8080 && four_bit_mode) else $error("8080 strap wrong");
  a_no_byte_deselect: assert property (pins.cs_n[*6] |-> !byte_out.valid)
    else $error("byte while deselected");
  a_read_drives: assert property ((bus_mode == MODE_P8080 && !pins.e_rd_n && !pins.cs_n
    && pins.chip_init_n)[*4] |-> d_oe_n == (four_bit_mode ? 8'h0F : 8'h00))
    else $error("read not driven");
  a_idle_released: assert property ((bus_mode == MODE_P8080 && pins.e_rd_n)[*4]
    |-> d_oe_n == 8'hFF) else $error("bus not released");
  a_serial_map: assert property ((bus_mode == MODE_SERIAL)[*6]
    |-> d_oe_n == 8'hFB && serial_out.shift_clk == $past(pins.d[0], 3))
    else $error("serial mapping wrong");
  a_i2c_map: assert property ((bus_mode == MODE_I2C)[*6]
    |-> serial_out.addr_lsb_strap == $past(pins.dc, 3)
    && serial_out.i2c_scl == $past(pins.d[0], 3)) else $error("I2C mapping wrong");
endmodule
bind mhp_host_port mhp_host_port_properties chk_u (.mclk(mclk), .srst(srst), .pins(pins),
  .d_oe_n(d_oe_n), .byte_out(byte_out), .mem_fetch(mem_fetch), .serial_out(serial_out),
  .bus_mode(bus_mode), .four_bit_mode(four_bit_mode));

// ### mhp_host_model.sv
// Host microcontroller model: drives strobes and data, reads back the bus.
// Assumes d_out and d_oe_n come straight from the port under test.
`timescale 1ns/1ps
module mhp_host_model (
  input wire logic mclk,
  input wire logic [7:0] d_out,
  input wire logic [7:0] d_oe_n,
  output mhp_pkg::mhp_pins_s pins
);
  import mhp_pkg::*;
  mhp_pins_s drv = {1'b1, 3'h4, 1'b1, 11'h000};
  logic cs_off = 1'b0;
  always_comb begin
    pins = drv;
    for (int i = 0; i < 8; i++) begin
      if (d_oe_n[i] == 1'b0) pins.d[i] = d_out[i];
    end
  end
  task automatic strobe(input logic is8080, rd, dc, input logic [7:0] v, output logic [7:0] q);
    drv.cs_n = cs_off;
    drv.dc = dc;
    drv.rw_wr_n = is8080 | rd;
    drv.e_rd_n = is8080;
    // A released bus shows the inverse of the last value, never a stale copy.
    drv.d = rd ? ~drv.d : v;
    repeat (4) @(posedge mclk);
    #1;
    if (!is8080) drv.e_rd_n = 1'b1;
    else if (rd) drv.e_rd_n = 1'b0;
    else drv.rw_wr_n = 1'b0;
    repeat (5) @(posedge mclk);
    q = pins.d;
    #1;
    drv.e_rd_n = is8080;
    drv.rw_wr_n = is8080 | rd;
    repeat (4) @(posedge mclk);
    #1;
    drv.cs_n = 1'b1;
    @(posedge mclk);
    #1;
  endtask
  task automatic xfer(input logic is8080, rd, dc, four, input logic [7:0] b,
                      output logic [7:0] q);
    logic [7:0] h;
    if (four) begin
      strobe(is8080, rd, dc, {b[7:4], 4'h0}, h);
      strobe(is8080, rd, dc, {b[3:0], 4'h0}, q);
      q = {h[7:4], q[7:4]};
    end else begin
      strobe(is8080, rd, dc, b, q);
    end
  endtask
endmodule

// ### mcu_parallel_host_port_test.sv
// Self-checking bench for the parallel host port in all six strap modes.
// Assumes the host model drives every pin; the core side is modelled here.
`timescale 1ns/1ps
module mcu_parallel_host_port_test;
  import mhp_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, sol = 1'b0, sda_lo = 1'b0, m8080, four, mem_fetch, fbm;
  logic [7:0] status_in = 8'h00, mem_rd_data = 8'h00, d_out, d_oe_n, q;
  mhp_pins_s pins;
  mhp_byte_s byte_out;
  mhp_serial_s serial_out;
  mhp_mode_e bus_mode;
  logic [8:0] expq[$];
  logic [2:0] straps[6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  int n_mismatch = 0, checks = 0;
  integer seed = 32'h9d69bd13;
  always #50 mclk = ~mclk;
  mhp_host_model host_u (.mclk(mclk), .d_out(d_out), .d_oe_n(d_oe_n), .pins(pins));
  mhp_host_port dut_u (.mclk(mclk), .ce(1'b1), .srst(srst), .pins(pins),
    .status_in(status_in), .mem_rd_data(mem_rd_data), .serial_out_line(sol),
    .i2c_sda_pull_low(sda_lo), .d_out(d_out), .d_oe_n(d_oe_n), .byte_out(byte_out),
    .mem_fetch(mem_fetch), .serial_out(serial_out), .bus_mode(bus_mode),
    .four_bit_mode(fbm));
  task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // An unexpected byte is compared against its own inverse so it always counts.
  always @(posedge mclk) begin
    if (byte_out.valid === 1'b1) begin
      chk("byte", expq.size() ? expq.pop_front() : ~{byte_out.is_data, byte_out.data},
          {byte_out.is_data, byte_out.data});
    end
  end
  task automatic wr(input logic dc, input logic [7:0] b);
    expq.push_back({dc, b});
    host_u.xfer(m8080, 1'b0, dc, four, b, q);
  endtask
  initial begin
    #5000000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    foreach (straps[k]) begin
      srst = 1'b1;
      host_u.drv.iface_select = straps[k];
      m8080 = straps[k][1];
      four = straps[k][0];
      // Park the strobes idle so the next mode sees no stray edge on select.
      host_u.drv.cs_n = 1'b1;
      host_u.drv.rw_wr_n = 1'b1;
      host_u.drv.e_rd_n = m8080;
      repeat (5) @(posedge mclk);
      #1;
      srst = 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      if (!straps[k][2]) begin
        host_u.drv.rw_wr_n = 1'b0;
        host_u.drv.e_rd_n = 1'b0;
        repeat (40) begin
          @(posedge mclk);
          #1;
          host_u.drv.d = 8'($random(seed));
          host_u.drv.dc = host_u.drv.d[3] & m8080;
          {sol, sda_lo} = host_u.drv.d[5:4];
        end
        repeat (4) @(posedge mclk);
        #1;
        chk("pin_map", {4'h0, host_u.drv.d[0], host_u.drv.d[1], host_u.drv.d[0],
            host_u.drv.d[1], host_u.drv.dc}, {4'h0, serial_out});
        chk("d_oe_n", m8080 ? {1'b0, 5'h1F, ~sda_lo, 2'h3} : 9'h0FB, {1'b0, d_oe_n});
        chk("d_out", m8080 ? 9'h000 : {6'h00, sol, 2'h0}, {1'b0, d_out});
      end else begin
        wr(1'b0, 8'($random(seed)));
        wr(1'b1, 8'($random(seed)));
        host_u.cs_off = 1'b1;
        host_u.xfer(m8080, 1'b0, 1'b1, four, 8'h5A, q);
        host_u.cs_off = 1'b0;
        status_in = 8'($random(seed));
        host_u.xfer(m8080, 1'b1, 1'b0, four, 8'h00, q);
        chk("status", {1'b0, status_in}, {1'b0, q});
        mem_rd_data = 8'($random(seed));
        host_u.xfer(m8080, 1'b1, 1'b1, four, 8'h00, q);
        chk("dummy", 9'h000, {1'b0, q});
        host_u.xfer(m8080, 1'b1, 1'b1, four, 8'h00, q);
        chk("rdata", {1'b0, mem_rd_data}, {1'b0, q});
        if (four) begin
          host_u.strobe(m8080, 1'b0, 1'b1, 8'hA0, q);
          host_u.drv.chip_init_n = 1'b0;
          repeat (5) @(posedge mclk);
          #1;
          host_u.drv.chip_init_n = 1'b1;
          repeat (5) @(posedge mclk);
          #1;
          wr(1'b1, 8'hC3);
        end
      end
      $display("strap %h done", straps[k]);
    end
    complete_run();
  end
endmodule
